//--- core/sar_consts.svh
// Register offsets, field positions, reset values and counts for sar_ctrl
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SAR_OFS_SC1 16'h0010
`define SAR_OFS_SC2 16'h0011
`define SAR_OFS_SC3 16'h0012
`define SAR_OFS_SC4 16'h0013
`define SAR_OFS_RH 16'h0014
`define SAR_OFS_RL 16'h0015
`define SAR_OFS_CVH 16'h0016
`define SAR_OFS_CVL 16'h0017
`define SAR_OFS_PDL 16'h30AC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAR_SC1_DONE 7
`define SAR_SC1_IRQEN 6
`define SAR_SC1_CONT 5
`define SAR_SC2_BUSY 7
`define SAR_SC2_HWT 6
`define SAR_SC2_CMPEN 1
`define SAR_SC2_CMPGE 0
`define SAR_SC3_DIV 5
`define SAR_SC3_MODE 2
`define SAR_SC3_CLK 0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SAR_CHAN_OFF 5'h1F
`define SAR_RST_BYTE 8'h00
`define SAR_RST_RES 12'h000
`define SAR_FIFO_MAX 4'h8

`endif

//--- core/sar_pkg.sv
// Types shared by the converter control logic
`default_nettype none
package sar_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } sar_state_type;

    typedef enum logic [1:0] {
        MODE_8 = 2'b00,
        MODE_12 = 2'b01,
        MODE_10 = 2'b10
    } sar_mode_type;

    typedef enum logic [1:0] {
        CLK_BUS = 2'b00,
        CLK_BUS2 = 2'b01,
        CLK_ALT = 2'b10,
        CLK_ASYNC = 2'b11
    } sar_clk_type;
endpackage
`default_nettype wire

//--- core/sar_ctrl.sv
// Control logic around a successive-approximation converter core
// ----------------------------------------------------------------
// How it works
// - Load results on completion unless compare fails
// - High byte read blocks transfers until low read
// - No interlock in 8-bit mode
// - 12-bit high register holds upper nibble only
// - FIFO results read back in channel order
// - FIFO set starts and ends at programmed depth
// - Resolution change invalidates both result registers
// - 12-bit compare uses nibble plus low byte
// - Pin-disable bit per channel 0-7, 1 disables
// - Disabled pin: no drive, reads zero, no pullup
// - Converter off in reset or channel all ones
// - Idle at lowest power between conversions
// - Round to 10 or 8 bits per mode
// - Set done flag, interrupt if enabled
// - Compare enable works in every mode
// - Four clock sources, bus clock after reset
// - Bus, bus/2, alternate, internal async clock
// - Divide selected source by 1, 2, 4, 8
// - Trigger rising edge starts when enabled
// - Trigger edge ignored during conversion
// - Continuous mode: only first trigger edge counts
// - Depth 000 off, else two to eight entries
// - Blocked transfer: flag left unchanged, result lost
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "sar_consts.svh"
`default_nettype none

module sar_ctrl (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic HW_TRIGGER_IN,
    input wire logic ALT_CLK_IN,
    input wire logic ASYNC_CLK_IN,
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_RESULT,
    output logic CONV_ENABLE,
    output logic CONV_START,
    output logic [4:0] CONV_CHANNEL,
    output logic [1:0] CONV_MODE,
    output logic CONV_CLK_EN,
    output logic ASYNC_CLK_REQ,
    output logic DONE_IRQ,
    input wire logic [7:0] PORT_OUT_EN,
    input wire logic [7:0] PORT_PULLUP_EN,
    input wire logic [7:0] PAD_IN,
    output logic [7:0] PAD_OUT_EN,
    output logic [7:0] PAD_PULLUP_EN,
    output logic [7:0] PAD_IN_BUF_EN,
    output logic [7:0] PORT_IN
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [11:0] round_fmt(input logic [11:0] raw,
                                              input logic [1:0] mode);
        logic [12:0] sum;
        sum = 13'h0000;
        round_fmt = raw;
        if (mode == sar_pkg::MODE_10) begin
            sum = {1'b0, raw} + 13'h0002;
            round_fmt = sum[12] ? 12'h03FF : {2'b00, sum[11:2]};
        end else if (mode != sar_pkg::MODE_12) begin
            sum = {1'b0, raw} + 13'h0008;
            round_fmt = sum[12] ? 12'h00FF : {4'h0, sum[11:4]};
        end
    endfunction

    function automatic logic [11:0] cmp_ref(input logic [3:0] hi,
                                            input logic [7:0] lo,
                                            input logic [1:0] mode);
        if (mode == sar_pkg::MODE_12) begin
            cmp_ref = {hi, lo};
        end else if (mode == sar_pkg::MODE_10) begin
            cmp_ref = {2'b00, hi[1:0], lo};
        end else begin
            cmp_ref = {4'h0, lo};
        end
    endfunction

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [2:0] trig_s_ff, nxt_trig_s;
    logic [2:0] alt_s_ff, nxt_alt_s;
    logic [2:0] asy_s_ff, nxt_asy_s;
    logic [7:0] pad_s1_ff, nxt_pad_s1;
    logic [7:0] pad_s2_ff, nxt_pad_s2;
    logic trig_rise;

    always_comb begin
        nxt_trig_s = {trig_s_ff[1:0], HW_TRIGGER_IN};
        nxt_alt_s = {alt_s_ff[1:0], ALT_CLK_IN};
        nxt_asy_s = {asy_s_ff[1:0], ASYNC_CLK_IN};
        nxt_pad_s1 = PAD_IN;
        nxt_pad_s2 = pad_s1_ff;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trig_s_ff <= 3'h0;
            alt_s_ff <= 3'h0;
            asy_s_ff <= 3'h0;
            pad_s1_ff <= `SAR_RST_BYTE;
            pad_s2_ff <= `SAR_RST_BYTE;
        end else begin
            trig_s_ff <= nxt_trig_s;
            alt_s_ff <= nxt_alt_s;
            asy_s_ff <= nxt_asy_s;
            pad_s1_ff <= nxt_pad_s1;
            pad_s2_ff <= nxt_pad_s2;
        end
    end

    assign trig_rise = trig_s_ff[1] & ~trig_s_ff[2];

    // ------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------
    logic [7:0] pdl_ff, nxt_pdl;

    assign PAD_OUT_EN = PORT_OUT_EN & ~pdl_ff;
    assign PAD_PULLUP_EN = PORT_PULLUP_EN & ~pdl_ff;
    assign PAD_IN_BUF_EN = ~pdl_ff;
    assign PORT_IN = pad_s2_ff & ~pdl_ff;

    // ------------------------------------------------------------
    // Registers and conversion sequencing
    // ------------------------------------------------------------
    sar_pkg::sar_state_type state_ff, nxt_state;
    logic done_ff, nxt_done;
    logic irq_en_ff, nxt_irq_en;
    logic cont_ff, nxt_cont;
    logic [4:0] chan_ff, nxt_chan;
    logic hwt_ff, nxt_hwt;
    logic cmp_en_ff, nxt_cmp_en;
    logic cmp_ge_ff, nxt_cmp_ge;
    logic [1:0] div_ff, nxt_div;
    logic [1:0] mode_ff, nxt_mode;
    logic [1:0] clk_ff, nxt_clk;
    logic [2:0] depth_ff, nxt_depth;
    logic [3:0] cvh_ff, nxt_cvh;
    logic [7:0] cvl_ff, nxt_cvl;
    logic [11:0] res_ff, nxt_res;
    logic lock_ff, nxt_lock;
    logic cont_run_ff, nxt_cont_run;
    logic start_ff, nxt_start;
    logic [4:0] cur_ff, nxt_cur;
    logic [3:0] idx_ff, nxt_idx;
    logic [4:0] chq_ff [0:7];
    logic [4:0] nxt_chq [0:7];
    logic [3:0] chq_cnt_ff, nxt_chq_cnt;
    logic [11:0] rq_ff [0:7];
    logic [11:0] nxt_rq [0:7];
    logic [2:0] rq_rd_ff, nxt_rq_rd;
    logic [3:0] rq_cnt_ff, nxt_rq_cnt;
    logic [7:0] rdata_ff, nxt_rdata;

    logic fifo_on;
    logic [3:0] level;
    logic [11:0] head;
    logic [11:0] rd_res;
    logic [11:0] val;
    logic cmp_ok;
    logic wr_sc1;
    logic cfg_wr;

    assign fifo_on = (depth_ff != 3'h0);
    assign level = {1'b0, depth_ff} + 4'h1;
    assign head = rq_ff[rq_rd_ff];
    assign rd_res = fifo_on ? head : res_ff;
    assign val = round_fmt(CONV_RESULT, mode_ff);
    assign wr_sc1 = WR && (ADDR == `SAR_OFS_SC1);
    assign cfg_wr = WR && ((ADDR == `SAR_OFS_SC2) ||
                           (ADDR == `SAR_OFS_SC3) ||
                           (ADDR == `SAR_OFS_SC4) ||
                           (ADDR == `SAR_OFS_CVH) ||
                           (ADDR == `SAR_OFS_CVL));

    always_comb begin
        cmp_ok = 1'b1;
        if (cmp_en_ff) begin
            if (cmp_ge_ff) begin
                cmp_ok = val >= cmp_ref(cvh_ff, cvl_ff, mode_ff);
            end else begin
                cmp_ok = val < cmp_ref(cvh_ff, cvl_ff, mode_ff);
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_done = done_ff;
        nxt_irq_en = irq_en_ff;
        nxt_cont = cont_ff;
        nxt_chan = chan_ff;
        nxt_hwt = hwt_ff;
        nxt_cmp_en = cmp_en_ff;
        nxt_cmp_ge = cmp_ge_ff;
        nxt_div = div_ff;
        nxt_mode = mode_ff;
        nxt_clk = clk_ff;
        nxt_depth = depth_ff;
        nxt_cvh = cvh_ff;
        nxt_cvl = cvl_ff;
        nxt_pdl = pdl_ff;
        nxt_res = res_ff;
        nxt_lock = lock_ff;
        nxt_cont_run = cont_run_ff;
        nxt_start = 1'b0;
        nxt_cur = cur_ff;
        nxt_idx = idx_ff;
        nxt_chq = chq_ff;
        nxt_chq_cnt = chq_cnt_ff;
        nxt_rq = rq_ff;
        nxt_rq_rd = rq_rd_ff;
        nxt_rq_cnt = rq_cnt_ff;
        nxt_rdata = 8'h00;

        // Reads come first so that a completion in the same cycle sees the lock, flag and FIFO state they leave
        if (RD) begin
            case (ADDR)
                `SAR_OFS_SC1: nxt_rdata = {done_ff, irq_en_ff,
                                           cont_ff, chan_ff};
                `SAR_OFS_SC2: nxt_rdata = {state_ff == sar_pkg::ST_BUSY,
                                           hwt_ff, 4'h0,
                                           cmp_en_ff, cmp_ge_ff};
                `SAR_OFS_SC3: nxt_rdata = {1'b0, div_ff, 1'b0,
                                           mode_ff, clk_ff};
                `SAR_OFS_SC4: nxt_rdata = {5'h00, depth_ff};
                `SAR_OFS_RH: begin
                    nxt_rdata = {4'h0, rd_res[11:8]};
                    if (mode_ff != sar_pkg::MODE_8) begin
                        nxt_lock = 1'b1;
                    end
                end
                `SAR_OFS_RL: begin
                    nxt_rdata = rd_res[7:0];
                    nxt_lock = 1'b0;
                    nxt_done = 1'b0;
                    if (fifo_on && rq_cnt_ff != 4'h0) begin
                        nxt_rq_rd = rq_rd_ff + 3'h1;
                        nxt_rq_cnt = rq_cnt_ff - 4'h1;
                    end
                end
                `SAR_OFS_CVH: nxt_rdata = {4'h0, cvh_ff};
                `SAR_OFS_CVL: nxt_rdata = cvl_ff;
                `SAR_OFS_PDL: nxt_rdata = pdl_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end

        if (WR) begin
            case (ADDR)
                `SAR_OFS_SC1: begin
                    nxt_irq_en = WDATA[`SAR_SC1_IRQEN];
                    nxt_cont = WDATA[`SAR_SC1_CONT];
                    nxt_chan = WDATA[4:0];
                end
                `SAR_OFS_SC2: begin
                    nxt_hwt = WDATA[`SAR_SC2_HWT];
                    nxt_cmp_en = WDATA[`SAR_SC2_CMPEN];
                    nxt_cmp_ge = WDATA[`SAR_SC2_CMPGE];
                end
                `SAR_OFS_SC3: begin
                    nxt_div = WDATA[`SAR_SC3_DIV +: 2];
                    nxt_mode = WDATA[`SAR_SC3_MODE +: 2];
                    nxt_clk = WDATA[`SAR_SC3_CLK +: 2];
                    if (WDATA[`SAR_SC3_MODE +: 2] != mode_ff) begin
                        nxt_res = `SAR_RST_RES;
                        nxt_rq_cnt = 4'h0;
                        nxt_lock = 1'b0;
                    end
                end
                `SAR_OFS_SC4: begin
                    nxt_depth = WDATA[2:0];
                    nxt_chq_cnt = 4'h0;
                end
                `SAR_OFS_CVH: nxt_cvh = WDATA[3:0];
                `SAR_OFS_CVL: nxt_cvl = WDATA;
                `SAR_OFS_PDL: nxt_pdl = WDATA;
                default: ;
            endcase
        end

        // A configuration write (SC2, SC3, SC4, CVH, CVL) abandons the running conversion
        if (cfg_wr) begin
            nxt_state = sar_pkg::ST_IDLE;
            nxt_cont_run = 1'b0;
        end

        if (wr_sc1) begin
            nxt_done = 1'b0;
            nxt_cont_run = 1'b0;
            nxt_state = sar_pkg::ST_IDLE;
            if (fifo_on) begin
                if (chq_cnt_ff >= level) begin
                    nxt_chq[0] = WDATA[4:0];
                    nxt_chq_cnt = 4'h1;
                end else begin
                    nxt_chq[chq_cnt_ff[2:0]] = WDATA[4:0];
                    nxt_chq_cnt = chq_cnt_ff + 4'h1;
                end
                if (nxt_chq_cnt == level && !hwt_ff) begin
                    nxt_state = sar_pkg::ST_BUSY;
                    nxt_start = 1'b1;
                    nxt_cur = nxt_chq[0];
                    nxt_idx = 4'h0;
                    nxt_cont_run = WDATA[`SAR_SC1_CONT];
                    nxt_rq_cnt = 4'h0;
                    nxt_rq_rd = 3'h0;
                end
            end else if (!hwt_ff && WDATA[4:0] != `SAR_CHAN_OFF) begin
                nxt_state = sar_pkg::ST_BUSY;
                nxt_start = 1'b1;
                nxt_cur = WDATA[4:0];
                nxt_cont_run = WDATA[`SAR_SC1_CONT];
            end
        end else if (!cfg_wr && trig_rise && hwt_ff &&
                     state_ff == sar_pkg::ST_IDLE &&
                     !cont_run_ff) begin
            if (fifo_on && chq_cnt_ff == level) begin
                nxt_state = sar_pkg::ST_BUSY;
                nxt_start = 1'b1;
                nxt_cur = chq_ff[0];
                nxt_idx = 4'h0;
                nxt_cont_run = cont_ff;
                nxt_rq_cnt = 4'h0;
                nxt_rq_rd = 3'h0;
            end else if (!fifo_on && chan_ff != `SAR_CHAN_OFF) begin
                nxt_state = sar_pkg::ST_BUSY;
                nxt_start = 1'b1;
                nxt_cur = chan_ff;
                nxt_cont_run = cont_ff;
            end
        end else if (!cfg_wr && CONV_DONE &&
                     state_ff == sar_pkg::ST_BUSY) begin
            if (nxt_lock) begin
                // Result lost; restart the same channel unless a failed compare ends a single non-FIFO conversion
                if (!cmp_ok && !cont_ff && !fifo_on) begin
                    nxt_state = sar_pkg::ST_IDLE;
                end else begin
                    nxt_start = 1'b1;
                end
            end else if (!fifo_on) begin
                if (cmp_ok) begin
                    nxt_res = val;
                    nxt_done = 1'b1;
                end
                if (cont_ff) begin
                    nxt_start = 1'b1;
                end else begin
                    nxt_state = sar_pkg::ST_IDLE;
                    nxt_cont_run = 1'b0;
                end
            end else begin
                if (cmp_ok && nxt_rq_cnt < `SAR_FIFO_MAX) begin
                    nxt_rq[3'(nxt_rq_rd + nxt_rq_cnt[2:0])] = val;
                    nxt_rq_cnt = nxt_rq_cnt + 4'h1;
                end
                if (idx_ff + 4'h1 >= level) begin
                    nxt_done = 1'b1;
                    nxt_idx = 4'h0;
                    if (cont_ff) begin
                        nxt_start = 1'b1;
                        nxt_cur = chq_ff[0];
                    end else begin
                        nxt_state = sar_pkg::ST_IDLE;
                        nxt_cont_run = 1'b0;
                    end
                end else begin
                    nxt_idx = idx_ff + 4'h1;
                    nxt_start = 1'b1;
                    nxt_cur = chq_ff[nxt_idx[2:0]];
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_ff <= sar_pkg::ST_IDLE;
            done_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            cont_ff <= 1'b0;
            chan_ff <= `SAR_CHAN_OFF;
            hwt_ff <= 1'b0;
            cmp_en_ff <= 1'b0;
            cmp_ge_ff <= 1'b0;
            div_ff <= 2'h0;
            mode_ff <= 2'h0;
            clk_ff <= 2'h0;
            depth_ff <= 3'h0;
            cvh_ff <= 4'h0;
            cvl_ff <= `SAR_RST_BYTE;
            pdl_ff <= `SAR_RST_BYTE;
            res_ff <= `SAR_RST_RES;
            lock_ff <= 1'b0;
            cont_run_ff <= 1'b0;
            start_ff <= 1'b0;
            cur_ff <= `SAR_CHAN_OFF;
            idx_ff <= 4'h0;
            chq_cnt_ff <= 4'h0;
            rq_rd_ff <= 3'h0;
            rq_cnt_ff <= 4'h0;
            rdata_ff <= `SAR_RST_BYTE;
            for (int i = 0; i < 8; i++) begin
                chq_ff[i] <= 5'h00;
                rq_ff[i] <= `SAR_RST_RES;
            end
        end else begin
            state_ff <= nxt_state;
            done_ff <= nxt_done;
            irq_en_ff <= nxt_irq_en;
            cont_ff <= nxt_cont;
            chan_ff <= nxt_chan;
            hwt_ff <= nxt_hwt;
            cmp_en_ff <= nxt_cmp_en;
            cmp_ge_ff <= nxt_cmp_ge;
            div_ff <= nxt_div;
            mode_ff <= nxt_mode;
            clk_ff <= nxt_clk;
            depth_ff <= nxt_depth;
            cvh_ff <= nxt_cvh;
            cvl_ff <= nxt_cvl;
            pdl_ff <= nxt_pdl;
            res_ff <= nxt_res;
            lock_ff <= nxt_lock;
            cont_run_ff <= nxt_cont_run;
            start_ff <= nxt_start;
            cur_ff <= nxt_cur;
            idx_ff <= nxt_idx;
            chq_cnt_ff <= nxt_chq_cnt;
            rq_rd_ff <= nxt_rq_rd;
            rq_cnt_ff <= nxt_rq_cnt;
            rdata_ff <= nxt_rdata;
            chq_ff <= nxt_chq;
            rq_ff <= nxt_rq;
        end
    end

    // ------------------------------------------------------------
    // Converter clock: source select and divider
    // ------------------------------------------------------------
    // Foreign clocks arrive as sampled edges, so alternate and async
    // sources must stay below half the bus clock rate.
    logic half_ff, nxt_half;
    logic [2:0] div_cnt_ff, nxt_div_cnt;
    logic tick_ff, nxt_tick;
    logic areq_ff, nxt_areq;
    logic src_tick;
    logic [2:0] ratio;

    always_comb begin
        case (clk_ff)
            sar_pkg::CLK_BUS: src_tick = 1'b1;
            sar_pkg::CLK_BUS2: src_tick = half_ff;
            sar_pkg::CLK_ALT: src_tick = alt_s_ff[1] & ~alt_s_ff[2];
            sar_pkg::CLK_ASYNC: src_tick = asy_s_ff[1] & ~asy_s_ff[2];
            default: src_tick = 1'b0;
        endcase
        case (div_ff)
            2'h0: ratio = 3'h0;
            2'h1: ratio = 3'h1;
            2'h2: ratio = 3'h3;
            2'h3: ratio = 3'h7;
            default: ratio = 3'h0;
        endcase
        nxt_half = ~half_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_tick = 1'b0;
        // Gated by the next state so that no tick outlives a conversion
        if (nxt_state != sar_pkg::ST_BUSY) begin
            nxt_div_cnt = 3'h0;
        end else if (src_tick) begin
            if (div_cnt_ff >= ratio) begin
                nxt_div_cnt = 3'h0;
                nxt_tick = 1'b1;
            end else begin
                nxt_div_cnt = div_cnt_ff + 3'h1;
            end
        end
        nxt_areq = (state_ff == sar_pkg::ST_BUSY) &&
                   (clk_ff == sar_pkg::CLK_ASYNC);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            half_ff <= 1'b0;
            div_cnt_ff <= 3'h0;
            tick_ff <= 1'b0;
            areq_ff <= 1'b0;
        end else begin
            half_ff <= nxt_half;
            div_cnt_ff <= nxt_div_cnt;
            tick_ff <= nxt_tick;
            areq_ff <= nxt_areq;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA = rdata_ff;
    assign CONV_ENABLE = (state_ff == sar_pkg::ST_BUSY) &&
                         (cur_ff != `SAR_CHAN_OFF);
    assign CONV_START = start_ff;
    assign CONV_CHANNEL = cur_ff;
    assign CONV_MODE = mode_ff;
    assign CONV_CLK_EN = tick_ff;
    assign ASYNC_CLK_REQ = areq_ff;
    assign DONE_IRQ = done_ff & irq_en_ff;

endmodule

`default_nettype wire

//--- test/sar_ctrl_properties.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic RD,
    input wire logic WR,
    input wire logic [7:0] RDATA,
    input wire logic CONV_DONE,
    input wire logic CONV_START,
    input wire logic CONV_ENABLE,
    input wire logic [4:0] CONV_CHANNEL,
    input wire logic CONV_CLK_EN,
    input wire logic DONE_IRQ,
    input wire logic [7:0] PORT_OUT_EN,
    input wire logic [7:0] PAD_OUT_EN,
    input wire logic [7:0] PAD_IN_BUF_EN,
    input wire logic [7:0] PORT_IN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_pad_oe; PAD_OUT_EN == (PORT_OUT_EN & PAD_IN_BUF_EN);
    endproperty
    a_pad_oe: assert property (p_pad_oe) else $error("pad drive");
    property p_pin_zero; (PORT_IN & ~PAD_IN_BUF_EN) == 8'h00; endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("pin read");
    property p_start_en; CONV_START |-> CONV_ENABLE && CONV_CHANNEL != 5'h1F;
    endproperty
    a_start_en: assert property (p_start_en) else $error("start off");
    property p_clk_en; CONV_CLK_EN |-> CONV_ENABLE; endproperty
    a_clk_en: assert property (p_clk_en) else $error("idle clock");
    property p_no_restart;
        CONV_ENABLE && !CONV_DONE && !WR |=> !CONV_START;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("restart");
    property p_irq; $rose(DONE_IRQ) |-> $past(CONV_DONE) || $past(WR);
    endproperty
    a_irq: assert property (p_irq) else $error("irq cause");
    property p_rh_nib; RD && ADDR == 16'h0014 |=> RDATA[7:4] == 4'h0;
    endproperty
    a_rh_nib: assert property (p_rh_nib) else $error("high nibble");
    property p_start_once; CONV_START |=> !CONV_START; endproperty
    a_start_once: assert property (p_start_once) else $error("double");
    c_start: cover property (CONV_START);
    c_done: cover property (CONV_DONE && CONV_ENABLE);
    c_irq: cover property ($rose(DONE_IRQ));
endmodule
`default_nettype wire

//--- test/sar_core_model.sv
// Behavioural converter core answering each start after a set delay
`timescale 1ns/1ps
`default_nettype none
module sar_core_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CONV_START,
    input wire logic [7:0] lat,
    input wire logic [11:0] val,
    output logic CONV_DONE,
    output logic [11:0] CONV_RESULT
);
    logic run_ff;
    logic [7:0] cnt_ff;
    // Result is only valid with the done pulse, so it churns otherwise
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            run_ff <= 1'b0;
            cnt_ff <= 8'h00;
            CONV_DONE <= 1'b0;
            CONV_RESULT <= 12'h000;
        end else begin
            CONV_DONE <= 1'b0;
            CONV_RESULT <= ~CONV_RESULT;
            cnt_ff <= cnt_ff - 8'h01;
            if (CONV_START) begin
                run_ff <= 1'b1;
                cnt_ff <= lat;
            end else if (run_ff && cnt_ff == 8'h00) begin
                run_ff <= 1'b0;
                CONV_DONE <= 1'b1;
                CONV_RESULT <= val;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/sar_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_bench;
    logic CLK, RST, WR, RD, HW_TRIGGER_IN, ALT_CLK_IN, ASYNC_CLK_IN;
    logic CONV_DONE, CONV_ENABLE, CONV_START, CONV_CLK_EN, ASYNC_CLK_REQ;
    logic DONE_IRQ;
    logic [15:0] ADDR;
    logic [11:0] CONV_RESULT, val;
    logic [7:0] WDATA, RDATA, PORT_OUT_EN, PORT_PULLUP_EN, PAD_IN, lat;
    logic [7:0] PAD_OUT_EN, PAD_PULLUP_EN, PAD_IN_BUF_EN, PORT_IN;
    logic [4:0] CONV_CHANNEL;
    logic [1:0] CONV_MODE;
    logic [23:0] tb[3] = '{24'h04_0FFE, 24'h08_03FF, 24'h00_00FF};
    int err_count = 0, checks = 0, starts = 0, s;
    sar_ctrl i_sar_ctrl (.*);
    sar_core_model i_sar_core_model (.*);
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) if (CONV_START) starts++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= w;
        RD <= !w;
        @(posedge CLK);
        {WR, RD} <= 2'b00;
        #1 if (!w) chk(RDATA, d);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Starts with a channel write when d is nonzero, then awaits completion
    task automatic go(input logic [7:0] d);
        if (d != 8'h00) bus(1, 16'h0010, d);
        for (int n = 0; CONV_DONE !== 1'b1; n++) begin
            if (n == 400) begin
                err_count++;
                wrap_up();
            end
            @(posedge CLK);
            #1;
        end
        repeat (2) @(posedge CLK);
    endtask
    initial begin
        {RST, WR, RD, HW_TRIGGER_IN, ALT_CLK_IN, ASYNC_CLK_IN} = 6'h20;
        {ADDR, WDATA, PORT_PULLUP_EN} = 32'h0000_00FF;
        {PORT_OUT_EN, PAD_IN, lat, val} = 36'hF_FA51_4FFE;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        bus(0, 16'h0016, 8'h00);
        bus(1, 16'h30AC, 8'h0F);
        bus(0, 16'h30AC, 8'h0F);
        chk({PAD_IN_BUF_EN, PORT_IN}, 16'hF0A0);
        chk({PAD_OUT_EN, PAD_PULLUP_EN}, 16'hF0F0);
        foreach (tb[i]) begin
            bus(1, 16'h0012, tb[i][23:16]);
            chk(CONV_MODE, tb[i][19:18]);
            bus(0, 16'h0015, 8'h00);
            go(8'h45);
            chk(DONE_IRQ, 1'b1);
            bus(0, 16'h0014, tb[i][15:8]);
            bus(0, 16'h0015, tb[i][7:0]);
        end
        bus(1, 16'h0012, 8'h04);
        val = 12'hABC;
        bus(0, 16'h0014, 8'h00);
        go(8'h45);
        chk(DONE_IRQ, 1'b0);
        bus(0, 16'h0015, 8'h00);
        go(8'h00);
        bus(0, 16'h0015, 8'hBC);
        bus(1, 16'h0016, 8'h01);
        bus(1, 16'h0017, 8'h00);
        bus(1, 16'h0011, 8'h02);
        val = 12'h123;
        go(8'h45);
        chk(DONE_IRQ, 1'b0);
        bus(0, 16'h0015, 8'hBC);
        val = 12'h0AB;
        go(8'h45);
        bus(0, 16'h0015, 8'hAB);
        bus(1, 16'h0011, 8'h40);
        bus(1, 16'h0010, 8'h43);
        lat = 8'h3C;
        s = starts;
        HW_TRIGGER_IN <= 1'b1;
        repeat (5) @(posedge CLK);
        chk(CONV_CHANNEL, 5'h03);
        HW_TRIGGER_IN <= 1'b0;
        repeat (3) @(posedge CLK);
        HW_TRIGGER_IN <= 1'b1;
        go(8'h00);
        chk(16'(starts - s), 16'h0001);
        bus(1, 16'h0011, 8'h00);
        bus(1, 16'h0013, 8'h01);
        bus(1, 16'h0010, 8'h41);
        val = 12'h111;
        go(8'h42);
        chk(DONE_IRQ, 1'b0);
        val = 12'h222;
        go(8'h00);
        chk(DONE_IRQ, 1'b1);
        bus(0, 16'h0014, 8'h01);
        bus(0, 16'h0015, 8'h11);
        bus(0, 16'h0014, 8'h02);
        bus(0, 16'h0015, 8'h22);
        wrap_up();
    end
endmodule
bind sar_ctrl sar_ctrl_properties i_sar_ctrl_properties (.*);
`default_nettype wire
